//--- rtl/dsw_cfg.svh
/*
 * Address map, field positions and fixed codes of the data-space decoder.
 * Assumes an 8-bit data-space address and a 12-bit program memory address.
 */
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

// ****************************************************************
// Banked region and read-only window
// ****************************************************************
`define DSW_BANK_LO 8'h00
`define DSW_BANK_HI 8'h3F
`define DSW_WIN_LO 8'h40
`define DSW_WIN_HI 8'h7F
`define DSW_OFS_BITS 6
`define DSW_PM_BITS 12

// ****************************************************************
// Local storage: core registers, general RAM, accumulator
// ****************************************************************
`define DSW_LOCAL_LO 8'h80
`define DSW_LOCAL_HI 8'hBF
`define DSW_ACC_ADDR 8'hFF
`define DSW_LOCAL_IDX_BASE 8'h40
`define DSW_ACC_IDX 8'h80
`define DSW_RAM_DEPTH 129

// ****************************************************************
// Fixed peripheral locations
// ****************************************************************
`define DSW_PORTA_DATA 8'hC0
`define DSW_PORTB_DATA 8'hC1
`define DSW_PORTC_DATA 8'hC2
`define DSW_PORTA_DIR 8'hC4
`define DSW_PORTB_DIR 8'hC5
`define DSW_PORTC_DIR 8'hC6
`define DSW_INT_OPT 8'hC8
`define DSW_PERIPH_LO 8'hC0
`define DSW_PERIPH_HI 8'hFE

// ****************************************************************
// Paging registers
// ****************************************************************
`define DSW_ROM_WINDOW_BASE 8'hC9
`define DSW_BANK_PAGE_SELECT 8'hE8
`define DSW_WINDOW_BASE_MSB 5
`define DSW_WINDOW_BASE_LSB 0
`define DSW_SEL_NONE 8'h00
`define DSW_SEL_NV_PAGE0 8'h01
`define DSW_SEL_NV_PAGE1 8'h02
`define DSW_SEL_RAM_PAGE2 8'h10
`define DSW_UNDEF_BYTE 8'hFF

`endif

//--- rtl/dsw_decoder.sv
/*
 * Data-space decoder: banked page region, program memory read window,
 * paging registers, local RAM and fixed peripheral selects.
 * Assumes a core that issues one read or write per cycle at most, and
 * external program memory, non-volatile pages and peripherals that answer
 * combinationally in the same cycle as their strobe.
 */
`timescale 1ns/1ns
`default_nettype none

`include "dsw_cfg.svh"

module dsw_decoder #(
	parameter int RAM_DEPTH = `DSW_RAM_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] core_addr,
	input wire logic core_rd,
	input wire logic core_wr,
	input wire logic [7:0] core_wdata,
	output logic [7:0] core_rdata,
	output logic core_rvalid,
	output logic [11:0] pm_addr,
	output logic pm_rd,
	input wire logic [7:0] pm_rdata,
	output logic nv_page,
	output logic nv_rd,
	output logic nv_wr,
	output logic [5:0] nv_addr,
	output logic [7:0] nv_wdata,
	input wire logic [7:0] nv_rdata,
	output logic per_rd,
	output logic per_wr,
	output dsw_pkg::dsw_periph_e per_kind,
	output logic [1:0] per_port,
	output logic [7:0] per_addr,
	output logic [7:0] per_wdata,
	input wire logic [7:0] per_rdata
);
	import dsw_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic dsw_target_e decode(input logic [7:0] a);
		dsw_target_e t;
		t = DSW_TGT_NONE;
		if (a <= `DSW_BANK_HI) begin
			t = DSW_TGT_BANK;
		end else if (a >= `DSW_WIN_LO && a <= `DSW_WIN_HI) begin
			t = DSW_TGT_WINDOW;
		end else if ((a >= `DSW_LOCAL_LO && a <= `DSW_LOCAL_HI) || a == `DSW_ACC_ADDR) begin
			t = DSW_TGT_LOCAL;
		end else if (a == `DSW_ROM_WINDOW_BASE) begin
			t = DSW_TGT_WBASE;
		end else if (a == `DSW_BANK_PAGE_SELECT) begin
			t = DSW_TGT_BSEL;
		end else if (a >= `DSW_PERIPH_LO && a <= `DSW_PERIPH_HI) begin
			t = DSW_TGT_PERIPH;
		end
		return t;
	endfunction

	// Index into local RAM: page 2 first, then 80h-BFh, then accumulator
	function automatic logic [7:0] local_index(input logic [7:0] a, input logic page2);
		logic [7:0] i;
		i = `DSW_UNDEF_BYTE;
		if (page2 && a <= `DSW_BANK_HI) begin
			i = a;
		end else if (a >= `DSW_LOCAL_LO && a <= `DSW_LOCAL_HI) begin
			i = a - `DSW_LOCAL_IDX_BASE;
		end else if (a == `DSW_ACC_ADDR) begin
			i = `DSW_ACC_IDX;
		end
		return i;
	endfunction

	function automatic dsw_periph_e periph_kind(input logic [7:0] a);
		dsw_periph_e k;
		unique case (a)
			`DSW_PORTA_DATA, `DSW_PORTB_DATA, `DSW_PORTC_DATA: begin
				k = DSW_PER_PORT_DATA;
			end
			`DSW_PORTA_DIR, `DSW_PORTB_DIR, `DSW_PORTC_DIR: begin
				k = DSW_PER_PORT_DIR;
			end
			`DSW_INT_OPT: begin
				k = DSW_PER_INT_OPT;
			end
			default: begin
				k = DSW_PER_OTHER;
			end
		endcase
		return k;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	dsw_dec_state_s st_q, st_d;
	dsw_mem_if mem_bus ();

	dsw_target_e tgt;
	logic sel_ram2;
	logic sel_nv0;
	logic sel_nv1;
	logic bank_ram;
	logic bank_nv;
	logic take_rd;

	// Only the three legal one-hot codes open a page; anything else,
	// including several bits at once, reaches nothing rather than
	// letting pages fight on the bus.
	always_comb begin
		sel_ram2 = (st_q.bank_sel == `DSW_SEL_RAM_PAGE2);
		sel_nv0 = (st_q.bank_sel == `DSW_SEL_NV_PAGE0);
		sel_nv1 = (st_q.bank_sel == `DSW_SEL_NV_PAGE1);
		bank_ram = sel_ram2;
		bank_nv = sel_nv0 || sel_nv1;
		tgt = decode(core_addr);
		take_rd = core_rd && !core_wr;
	end

	// ****************************************************************
	// Local RAM port
	// ****************************************************************
	always_comb begin
		mem_bus.idx = local_index(core_addr, bank_ram);
		mem_bus.wdata = core_wdata;
		mem_bus.we = core_wr && ((tgt == DSW_TGT_LOCAL) || (tgt == DSW_TGT_BANK && bank_ram));
		// A pending local read below 40h can only be a RAM page 2 read
		mem_bus.ridx = local_index(st_q.per_addr, st_q.tgt == DSW_TGT_LOCAL);
	end

	dsw_local_ram #(
		.DEPTH(RAM_DEPTH)
	) u_ram (
		.ref_clk(ref_clk),
		.mem(mem_bus)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		st_d.pm_rd = 1'b0;
		st_d.nv_rd = 1'b0;
		st_d.nv_wr = 1'b0;
		st_d.per_rd = 1'b0;
		st_d.per_wr = 1'b0;
		st_d.rd_valid = 1'b0;
		st_d.pend = 1'b0;

		// Second cycle of a read: answers from outside are in now
		if (st_q.pend) begin
			st_d.rd_valid = 1'b1;
			unique case (st_q.tgt)
				DSW_TGT_WINDOW: begin
					st_d.rd_data = pm_rdata;
				end
				DSW_TGT_BANK: begin
					st_d.rd_data = nv_rdata;
				end
				DSW_TGT_LOCAL: begin
					st_d.rd_data = mem_bus.rdata;
				end
				DSW_TGT_PERIPH: begin
					st_d.rd_data = per_rdata;
				end
				default: begin
					st_d.rd_data = `DSW_UNDEF_BYTE;
				end
			endcase
		end

		// Write side: paging registers load at the edge, so the next
		// access already sees the new value
		if (core_wr) begin
			st_d.wdata = core_wdata;
			unique case (tgt)
				DSW_TGT_WBASE: begin
					st_d.win_base = core_wdata[`DSW_WINDOW_BASE_MSB:`DSW_WINDOW_BASE_LSB];
				end
				DSW_TGT_BSEL: begin
					st_d.bank_sel = core_wdata;
				end
				DSW_TGT_BANK: begin
					st_d.nv_wr = bank_nv;
					st_d.nv_page = sel_nv1;
					st_d.nv_addr = core_addr[`DSW_OFS_BITS-1:0];
				end
				DSW_TGT_PERIPH: begin
					st_d.per_wr = 1'b1;
					st_d.per_kind = periph_kind(core_addr);
					st_d.per_port = core_addr[1:0];
					st_d.per_addr = core_addr;
				end
				default: begin
				end
			endcase
		end else if (take_rd) begin
			st_d.pend = 1'b1;
			st_d.tgt = tgt;
			st_d.per_addr = core_addr;
			unique case (tgt)
				DSW_TGT_WINDOW: begin
					st_d.pm_rd = 1'b1;
					st_d.pm_addr = {st_q.win_base, core_addr[`DSW_OFS_BITS-1:0]};
				end
				DSW_TGT_BANK: begin
					st_d.nv_rd = bank_nv;
					st_d.nv_page = sel_nv1;
					st_d.nv_addr = core_addr[`DSW_OFS_BITS-1:0];
					st_d.tgt = bank_ram ? DSW_TGT_LOCAL : (bank_nv ? DSW_TGT_BANK : DSW_TGT_NONE);
				end
				DSW_TGT_PERIPH: begin
					st_d.per_rd = 1'b1;
					st_d.per_kind = periph_kind(core_addr);
					st_d.per_port = core_addr[1:0];
				end
				default: begin
				end
			endcase
		end

		// Reset clears the handshake but not the paging registers
		if (rst) begin
			st_d.pend = 1'b0;
			st_d.tgt = DSW_TGT_NONE;
			st_d.pm_addr = 12'h000;
			st_d.pm_rd = 1'b0;
			st_d.nv_page = 1'b0;
			st_d.nv_rd = 1'b0;
			st_d.nv_wr = 1'b0;
			st_d.nv_addr = 6'h00;
			st_d.per_rd = 1'b0;
			st_d.per_wr = 1'b0;
			st_d.per_kind = DSW_PER_OTHER;
			st_d.per_port = 2'b00;
			st_d.per_addr = 8'h00;
			st_d.wdata = 8'h00;
			st_d.rd_data = 8'h00;
			st_d.rd_valid = 1'b0;
			st_d.win_base = st_q.win_base;
			st_d.bank_sel = st_q.bank_sel;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_q <= st_d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign core_rdata = st_q.rd_data;
	assign core_rvalid = st_q.rd_valid;
	assign pm_addr = st_q.pm_addr;
	assign pm_rd = st_q.pm_rd;
	assign nv_page = st_q.nv_page;
	assign nv_rd = st_q.nv_rd;
	assign nv_wr = st_q.nv_wr;
	assign nv_addr = st_q.nv_addr;
	assign nv_wdata = st_q.wdata;
	assign per_rd = st_q.per_rd;
	assign per_wr = st_q.per_wr;
	assign per_kind = st_q.per_kind;
	assign per_port = st_q.per_port;
	assign per_addr = st_q.per_addr;
	assign per_wdata = st_q.wdata;
endmodule

`default_nettype wire

//--- rtl/dsw_local_ram.sv
/*
 * Local data RAM: RAM page 2, core registers, 60-byte general RAM, accumulator.
 * Assumes the decoder supplies linear indices below the depth.
 */
`timescale 1ns/1ns
`default_nettype none

`include "dsw_cfg.svh"

module dsw_local_ram #(
	parameter int DEPTH = `DSW_RAM_DEPTH
) (
	input wire logic ref_clk,
	dsw_mem_if.mem mem
);
	import dsw_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] cells;
	} dsw_ram_state_s;

	dsw_ram_state_s st_q, st_d;

	// Contents are not cleared by reset, as with any RAM
	always_comb begin
		st_d = st_q;
		if (mem.we && (int'(mem.idx) < DEPTH)) begin
			st_d.cells[mem.idx] = mem.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_q <= st_d;
	end

	assign mem.rdata = (int'(mem.ridx) < DEPTH) ? st_q.cells[mem.ridx] : `DSW_UNDEF_BYTE;
endmodule

`default_nettype wire

//--- rtl/dsw_mem_if.sv
/*
 * Carrier between the decoder and its local RAM.
 * Assumes one clock; read data is combinational from the array.
 */
`timescale 1ns/1ns
`default_nettype none

interface dsw_mem_if;
	logic we;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic [7:0] ridx;
	logic [7:0] rdata;

	modport ctrl (output we, output idx, output wdata, output ridx, input rdata);
	modport mem (input we, input idx, input wdata, input ridx, output rdata);
endinterface

`default_nettype wire

//--- rtl/dsw_pkg.sv
/*
 * Types shared by the data-space decoder and its local RAM.
 * Assumes dsw_cfg.svh for all numeric constants.
 */
package dsw_pkg;

	typedef enum logic [2:0] {
		DSW_TGT_NONE,
		DSW_TGT_BANK,
		DSW_TGT_WINDOW,
		DSW_TGT_LOCAL,
		DSW_TGT_WBASE,
		DSW_TGT_BSEL,
		DSW_TGT_PERIPH
	} dsw_target_e;

	typedef enum logic [2:0] {
		DSW_PER_OTHER,
		DSW_PER_PORT_DATA,
		DSW_PER_PORT_DIR,
		DSW_PER_INT_OPT
	} dsw_periph_e;

	typedef struct packed {
		logic [5:0] win_base;
		logic [7:0] bank_sel;
		logic pend;
		dsw_target_e tgt;
		logic [11:0] pm_addr;
		logic pm_rd;
		logic nv_page;
		logic nv_rd;
		logic nv_wr;
		logic [5:0] nv_addr;
		logic per_rd;
		logic per_wr;
		dsw_periph_e per_kind;
		logic [1:0] per_port;
		logic [7:0] per_addr;
		logic [7:0] wdata;
		logic [7:0] rd_data;
		logic rd_valid;
	} dsw_dec_state_s;

endpackage

//--- test/data_space_window_banking_tb.sv
/*
 * Self-checking bench for dsw_decoder with the far-side model.
 * Assumes read answers two cycles after the take edge.
 */
`timescale 1ns/1ns
`default_nettype none

module data_space_window_banking_tb;
	import dsw_pkg::*;

	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] x;
	} dsw_row_s;

	logic ref_clk, rst, core_rd, core_wr, core_rvalid, pm_rd, nv_page, nv_rd, nv_wr, per_rd, per_wr;
	logic [7:0] core_addr, core_wdata, core_rdata, pm_rdata, nv_wdata, nv_rdata;
	logic [7:0] per_addr, per_wdata, per_rdata;
	logic [11:0] pm_addr;
	logic [5:0] nv_addr;
	logic [1:0] per_port;
	dsw_periph_e per_kind;
	int fail_count = 0;
	int n_compared = 0;
	dsw_row_s rows [0:29];

	dsw_decoder DUT (.ref_clk(ref_clk), .rst(rst), .core_addr(core_addr), .core_rd(core_rd),
		.core_wr(core_wr), .core_wdata(core_wdata), .core_rdata(core_rdata),
		.core_rvalid(core_rvalid), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
		.nv_page(nv_page), .nv_rd(nv_rd), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
		.nv_rdata(nv_rdata), .per_rd(per_rd), .per_wr(per_wr), .per_kind(per_kind),
		.per_port(per_port), .per_addr(per_addr), .per_wdata(per_wdata), .per_rdata(per_rdata));

	dsw_far_model u_far (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
		.nv_page(nv_page), .nv_rd(nv_rd), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
		.nv_rdata(nv_rdata), .per_rd(per_rd), .per_addr(per_addr), .per_rdata(per_rdata));

	// ****************
	// Tasks
	// ****************
	task automatic go(input logic wr, input logic [7:0] a, input logic [7:0] d);
		core_wr = wr;
		core_rd = !wr;
		core_addr = a;
		core_wdata = d;
		@(posedge ref_clk);
		#10;
	endtask

	task automatic idle();
		core_wr = 1'b0;
		core_rd = 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Well beyond the fewer than a hundred cycles the tests need
	initial begin
		#200000;
		fail_count++;
		results();
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		rst = 1'b1;
		core_rd = 1'b0;
		core_wr = 1'b0;
		core_addr = 8'h00;
		core_wdata = 8'h00;
		// Base before window, bank before banked access
		// Code 08 sets one bit yet opens no page no row-write mode is used
		// Paging registers are only written, never read back
		rows = '{'{1'b1, 8'hC9, 8'hC5, 8'h00}, '{1'b0, 8'h47, 8'h00, 8'h53},
			'{1'b1, 8'h45, 8'h11, 8'h00}, '{1'b0, 8'h45, 8'h00, 8'h51},
			'{1'b1, 8'hE8, 8'h01, 8'h00}, '{1'b1, 8'h12, 8'h3C, 8'h00},
			'{1'b0, 8'h12, 8'h00, 8'h3C}, '{1'b1, 8'hE8, 8'h02, 8'h00},
			'{1'b1, 8'h12, 8'h99, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h99},
			'{1'b1, 8'hE8, 8'h01, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h3C},
			'{1'b1, 8'hE8, 8'h10, 8'h00}, '{1'b1, 8'h12, 8'h77, 8'h00},
			'{1'b0, 8'h12, 8'h00, 8'h77}, '{1'b1, 8'hE8, 8'h00, 8'h00},
			'{1'b0, 8'h12, 8'h00, 8'hFF}, '{1'b1, 8'h12, 8'h55, 8'h00},
			'{1'b1, 8'hE8, 8'h08, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'hFF},
			'{1'b1, 8'hE8, 8'h01, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h3C},
			'{1'b0, 8'hC3, 8'h00, 8'h99}, '{1'b0, 8'hC7, 8'h00, 8'h9D},
			'{1'b1, 8'h90, 8'h5E, 8'h00}, '{1'b0, 8'h90, 8'h00, 8'h5E},
			'{1'b1, 8'hC1, 8'h00, 8'h00}, '{1'b1, 8'hC5, 8'h00, 8'h00},
			'{1'b1, 8'hC8, 8'h00, 8'h00}, '{1'b0, 8'hC2, 8'h00, 8'h98}};
		repeat (12) @(posedge ref_clk);
		#10;
		rst = 1'b0;
		foreach (rows[i]) begin
			go(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) begin
				idle();
				@(posedge ref_clk);
				#10;
				chk({7'h00, core_rvalid}, 8'h01);
				chk(core_rdata, rows[i].x);
			end
		end
		$display("table test done");

		// Base written, then two window reads back to back at the top of memory
		go(1'b1, 8'h91, 8'h3F);
		go(1'b1, 8'hC9, 8'h3F);
		go(1'b0, 8'h7F, 8'h00);
		go(1'b0, 8'h40, 8'h00);
		idle();
		chk(core_rdata, 8'h03);
		@(posedge ref_clk);
		#10;
		chk(core_rdata, 8'h3C);
		$display("back to back test done");

		// Bank select rewritten as interrupt code would: shadow copy first
		go(1'b1, 8'h92, 8'h10);
		go(1'b1, 8'hE8, 8'h10);
		go(1'b0, 8'h12, 8'h00);
		idle();
		@(posedge ref_clk);
		#10;
		chk(core_rdata, 8'h77);
		go(1'b0, 8'h92, 8'h00);
		idle();
		@(posedge ref_clk);
		#10;
		chk(core_rdata, 8'h10);
		go(1'b1, 8'hC5, 8'hA7);
		chk(per_wdata, 8'hA7);
		chk({5'h00, per_kind}, {5'h00, DSW_PER_PORT_DIR});
		chk({5'h00, per_wr, per_port}, 8'h05);
		$display("shadow and port write test done");

		// A reset in mid-run kills a read in flight but keeps the window base
		go(1'b0, 8'h7F, 8'h00);
		idle();
		rst = 1'b1;
		@(posedge ref_clk);
		#10;
		chk({6'h00, core_rvalid, pm_rd}, 8'h00);
		@(posedge ref_clk);
		#10;
		rst = 1'b0;
		go(1'b0, 8'h7F, 8'h00);
		idle();
		@(posedge ref_clk);
		#10;
		chk(core_rdata, 8'h03);
		$display("reset retention test done");
		results();
	end
endmodule

`default_nettype wire

//--- test/dsw_decoder_properties.sv
/*
 * Port checker for the data-space decoder, bound into dsw_decoder.
 * Assumes dsw_pkg is compiled first and reads answer two cycles after the take edge.
 */
`timescale 1ns/1ns
`default_nettype none

module dsw_decoder_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] core_addr,
	input wire logic core_rd,
	input wire logic core_wr,
	input wire logic [7:0] core_wdata,
	input wire logic [7:0] core_rdata,
	input wire logic core_rvalid,
	input wire logic [11:0] pm_addr,
	input wire logic pm_rd,
	input wire logic [7:0] pm_rdata,
	input wire logic nv_wr,
	input wire logic [5:0] nv_addr,
	input wire logic per_wr,
	input wire dsw_pkg::dsw_periph_e per_kind,
	input wire logic [1:0] per_port
);
	import dsw_pkg::*;

	logic rd_take;
	logic win;
	assign rd_take = core_rd && !core_wr;
	assign win = core_addr[7:6] == 2'b01;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ****************
	// Assertions
	// ****************
	a_read_answer: assert property (rd_take |-> ##2 core_rvalid)
		else $error("read got no answer");
	a_win_addr: assert property (
		rd_take && win |=> pm_rd && pm_addr[5:0] == $past(core_addr[5:0]))
		else $error("window offset wrong");
	a_win_data: assert property (pm_rd |=> core_rvalid && core_rdata == $past(pm_rdata))
		else $error("window data not returned");
	a_base_step: assert property (
		core_wr && core_addr == 8'hC9 ##1 rd_take && win
		|=> pm_addr[11:6] == $past(core_wdata[5:0], 2))
		else $error("window base not applied");
	a_win_readonly: assert property (core_wr && win |=> !nv_wr && !per_wr && !pm_rd)
		else $error("window write reached memory");
	a_nv_offset: assert property (
		nv_wr |-> nv_addr == $past(core_addr[5:0]) && $past(core_addr[7:6]) == 2'b00)
		else $error("page offset wrong");
	a_port_data: assert property (
		core_wr && core_addr inside {8'hC0, 8'hC1, 8'hC2}
		|=> per_wr && per_kind == DSW_PER_PORT_DATA && per_port == $past(core_addr[1:0]))
		else $error("port data decode wrong");
	a_port_dir: assert property (
		core_wr && core_addr inside {8'hC4, 8'hC5, 8'hC6}
		|=> per_wr && per_kind == DSW_PER_PORT_DIR && per_port == $past(core_addr[1:0]))
		else $error("port direction decode wrong");
	a_int_opt: assert property (
		core_wr && core_addr == 8'hC8 |=> per_wr && per_kind == DSW_PER_INT_OPT)
		else $error("interrupt option decode wrong");

	c_win_read: cover property (pm_rd);
	c_nv_write: cover property (nv_wr);
	c_per_write: cover property (per_wr);
endmodule

bind dsw_decoder dsw_decoder_properties u_props (.ref_clk, .rst, .core_addr, .core_rd, .core_wr,
	.core_wdata, .core_rdata, .core_rvalid, .pm_addr, .pm_rd, .pm_rdata, .nv_wr, .nv_addr,
	.per_wr, .per_kind, .per_port);

`default_nettype wire

//--- test/dsw_far_model.sv
/*
 * Program memory, non-volatile pages and peripherals facing the decoder.
 * Assumes answers are wanted combinationally in the strobe cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module dsw_far_model (
	input wire logic ref_clk,
	input wire logic [11:0] pm_addr,
	input wire logic pm_rd,
	output logic [7:0] pm_rdata,
	input wire logic nv_page,
	input wire logic nv_rd,
	input wire logic nv_wr,
	input wire logic [5:0] nv_addr,
	input wire logic [7:0] nv_wdata,
	output logic [7:0] nv_rdata,
	input wire logic per_rd,
	input wire logic [7:0] per_addr,
	output logic [7:0] per_rdata
);
	logic [7:0] nv_mem [0:127];
	logic [7:0] pm_byte;
	logic [7:0] nv_byte;
	logic [7:0] per_byte;

	// Off-strobe the buses show the inverse, so a stale sample never matches
	assign pm_byte = pm_addr[7:0] ^ {pm_addr[11:6], 2'b00};
	assign pm_rdata = pm_rd ? pm_byte : ~pm_byte;
	assign nv_byte = nv_mem[{nv_page, nv_addr}];
	assign nv_rdata = nv_rd ? nv_byte : ~nv_byte;
	assign per_byte = per_addr ^ 8'h5A;
	assign per_rdata = per_rd ? per_byte : ~per_byte;

	always_ff @(posedge ref_clk) begin
		if (nv_wr)
			nv_mem[{nv_page, nv_addr}] <= nv_wdata;
	end
endmodule

`default_nettype wire
